// ==== include/spr_regs.svh ====
// spr_regs.svh: command word layout, page geometry and link timing of the paged register port
// assumes: included by bare name from the design files; definitions only
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// command word fields
`define SPR_CMD_RW_BIT 15
`define SPR_CMD_PG_MSB 14
`define SPR_CMD_PG_LSB 11
`define SPR_CMD_AD_MSB 10
`define SPR_CMD_AD_LSB 5
`define SPR_CMD_RSVD 5'h00
`define SPR_CMD_READ 1'h1

// word and page geometry
`define SPR_LAST_BIT 4'hF
`define SPR_NUM_PAGES 4'h3
`define SPR_PAGE_REGS 7'h20
`define SPR_REG_COUNT 96
`define SPR_ALL_ONES 16'hFFFF
`define SPR_BUF_DEPTH 2'h2

// link timing: system clock period and serial clock half period
`define SPR_CLK_NS 25
`define SPR_HALF_NS 100
`define SPR_HALF_CYC ((`SPR_HALF_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS)

`endif

// ==== include/spr_pkg.sv ====
// spr_pkg.sv: shared types of the paged register port
// assumes: compiled before the interface and both ends
package spr_pkg;
  typedef logic [15:0] spr_word_t;

  // host end sequencer
  typedef enum logic [2:0] {
    SPR_IDLE = 3'h0,
    SPR_SETUP = 3'h1,
    SPR_HIGH = 3'h2,
    SPR_LOW = 3'h3,
    SPR_WEND = 3'h4,
    SPR_DONE = 3'h5
  } spr_hstate_e;
endpackage

// ==== include/spr_link_if.sv ====
// spr_link_if.sv: four-wire serial link between the host end and the device end
// assumes: host drives clock, select and data in; device drives data out with an enable
`timescale 1ns/1ps
`default_nettype none
interface spr_link_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // undriven data out line reads low, as with a weak pull-down
  assign miso = miso_oe ? miso_out : 1'b0;

  modport host (output sclk, output ss_n, output mosi, input miso);
  modport dev (input sclk, input ss_n, input mosi, output miso_out, output miso_oe);
endinterface
`default_nettype wire

// ==== rtl/spr_host.sv ====
// spr_host.sv: bus master end; turns user commands into framed serial transfers
// assumes: clock at 40 MHz; serial clock made here by division; device end on the other side
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"
module spr_host (
  // serial link
  spr_link_if.host link,
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [3:0] cmd_page,
  input wire logic [5:0] cmd_addr,
  input wire logic [5:0] cmd_words,
  // write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  // read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_data,
  // status
  output logic busy
);
  spr_pkg::spr_hstate_e state;
  logic [3:0] half_cnt;
  logic half_done;
  logic [3:0] bit_cnt;
  logic [5:0] words_left;
  logic is_cmd;
  logic is_read;
  spr_pkg::spr_word_t tx_sh;
  spr_pkg::spr_word_t rx_sh;
  spr_pkg::spr_word_t rx_word;
  logic miso_meta;
  logic miso_s;
  logic word_end;
  logic go_next;
  logic push;
  logic pop;
  logic full;
  spr_pkg::spr_word_t buf_data [0:1];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;

  // data out comes from the device's link domain, so it is resynchronised first
  always_ff @(posedge clock) begin
    miso_meta <= link.miso;
    miso_s <= miso_meta;
  end

  assign half_done = (half_cnt == 4'(`SPR_HALF_CYC - 1));
  assign word_end = (state == spr_pkg::SPR_HIGH) && half_done && (bit_cnt == `SPR_LAST_BIT);
  assign rx_word = {rx_sh[14:0], miso_s};
  assign full = (buf_cnt == `SPR_BUF_DEPTH);
  // next word starts only when its data is there or its landing space is free
  assign go_next = (state == spr_pkg::SPR_WEND) && (words_left != 6'h00) && (is_read ? !full : wr_valid);
  assign cmd_ready = (state == spr_pkg::SPR_IDLE);
  assign wr_ready = (state == spr_pkg::SPR_WEND) && (words_left != 6'h00) && !is_read;
  assign busy = (state != spr_pkg::SPR_IDLE);

  // sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= spr_pkg::SPR_IDLE;
    end else begin
      unique case (state)
        spr_pkg::SPR_IDLE: if (cmd_valid) state <= spr_pkg::SPR_SETUP;
        spr_pkg::SPR_SETUP: if (half_done) state <= spr_pkg::SPR_HIGH;
        spr_pkg::SPR_HIGH: if (half_done) state <= word_end ? spr_pkg::SPR_WEND : spr_pkg::SPR_LOW;
        spr_pkg::SPR_LOW: if (half_done) state <= spr_pkg::SPR_HIGH;
        spr_pkg::SPR_WEND: begin
          if (words_left == 6'h00) state <= spr_pkg::SPR_DONE;
          else if (go_next) state <= spr_pkg::SPR_LOW;
        end
        spr_pkg::SPR_DONE: if (half_done) state <= spr_pkg::SPR_IDLE;
        default: state <= spr_pkg::SPR_IDLE;
      endcase
    end
  end

  // half period timer; waiting states hold it at zero
  always_ff @(posedge clock) begin
    if (sys_rst || state == spr_pkg::SPR_IDLE || state == spr_pkg::SPR_WEND || half_done) half_cnt <= 4'h0;
    else half_cnt <= half_cnt + 4'h1;
  end

  // link pins: clock idles low, data changes on the rising edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link.sclk <= 1'b0; // see (R1) (R2)
      link.ss_n <= 1'b1;
      link.mosi <= 1'b0;
      tx_sh <= 16'h0000;
    end else begin
      if (state == spr_pkg::SPR_IDLE && cmd_valid) begin
        link.ss_n <= 1'b0; // see (R5)
        tx_sh <= {cmd_read, cmd_page, cmd_addr, `SPR_CMD_RSVD}; // see (R6) (R7) (R8) (R9) (R10) (R11) (R14)
      end
      if (half_done && (state == spr_pkg::SPR_SETUP || state == spr_pkg::SPR_LOW)) begin
        link.sclk <= 1'b1;
        link.mosi <= tx_sh[15]; // see (R3)
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
      if (half_done && state == spr_pkg::SPR_HIGH) link.sclk <= 1'b0;
      if (go_next) tx_sh <= is_read ? 16'h0000 : wr_data;
      if (state == spr_pkg::SPR_WEND && words_left == 6'h00) link.ss_n <= 1'b1;
    end
  end

  // receive shifter and word bookkeeping; sampling on the falling edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_sh <= 16'h0000;
      bit_cnt <= 4'h0;
      words_left <= 6'h00;
      is_cmd <= 1'b0;
      is_read <= 1'b0;
    end else begin
      if (state == spr_pkg::SPR_IDLE && cmd_valid) begin
        bit_cnt <= 4'h0;
        words_left <= cmd_words;
        is_cmd <= 1'b1;
        is_read <= (cmd_read == `SPR_CMD_READ);
      end
      if (half_done && state == spr_pkg::SPR_HIGH) begin
        rx_sh <= rx_word;
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (go_next) begin
        words_left <= words_left - 6'h01;
        is_cmd <= 1'b0;
      end
    end
  end

  // two-entry read buffer; room was checked before the word started
  assign push = word_end && !is_cmd && is_read;
  assign pop = rd_valid && rd_ready;
  assign rd_valid = (buf_cnt != 2'h0);
  assign rd_data = buf_data[buf_rp];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) buf_wp <= ~buf_wp;
      if (pop) buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock) begin
    if (push) buf_data[buf_wp] <= rx_word;
  end
endmodule
`default_nettype wire

// ==== rtl/spr_dev.sv ====
// spr_dev.sv: serial slave end of the paged register port, with its register file
// assumes: link clock idles low and runs only inside frames; sys_rst and clock belong to the user side
// assumes: the host end takes data out between one rising serial edge and the next
// Notes on behaviour
// (R1) only the master clocks and starts transfers
// (R2) serial clock idles low between transfers
// (R3) both sides drive data on first clock edge
// (R4) data shifts in and out at once
// (R5) commands only count after select falls
// (R6) master sends command word before any data
// (R7) top command bit: one reads, zero writes
// (R8) next four bits pick page; others reserved
// (R9) next six bits give starting register index
// (R10) master sends low five bits as zero
// (R11) command 0x8000 reads from page 0 start
// (R12) pointer advances per word to page end
// (R13) reads past page end return all ones
// (R14) command 0x0800 writes from page 1 start
// (R15) every register word is sixteen bits
// (R16) writes store word, then advance pointer
// (R17) reserved pages: no writes, reads all ones
// (R18) select rise ends access; fall restarts command
`timescale 1ns/1ps
`default_nettype none
`include "spr_regs.svh"
module spr_dev (
  // serial link, clocked by the link's own clock
  spr_link_if.dev link,
  // user side, system clock domain
  input wire logic clock,
  input wire logic sys_rst,
  // register write notice
  output logic wr_pulse,
  output logic [1:0] wr_page,
  output logic [4:0] wr_addr,
  output logic [15:0] wr_data
);
  // reset as seen in the link domain
  logic rst_meta;
  logic link_rst;

  // frame position and incoming shifter
  logic [3:0] bit_cnt;
  logic cmd_phase;
  logic [14:0] in_sh;
  spr_pkg::spr_word_t word_in;
  logic word_done;

  // decoded command and address pointer
  logic dir_read;
  logic [3:0] page;
  logic [6:0] ptr;
  logic page_ok;
  logic in_page;
  logic [6:0] reg_idx;
  logic reg_we;

  // register file and outgoing word
  spr_pkg::spr_word_t rd_word;
  spr_pkg::spr_word_t regs [0:`SPR_REG_COUNT-1];

  // write notice crossing into the system clock domain
  logic note_tgl;
  logic [22:0] note_word;
  logic tgl_meta;
  logic tgl_s;
  logic tgl_prev;

  // reset carried into the link domain; needs a few link clock edges to take hold
  // the serial clock runs only inside frames, so a reset given while the link is
  // quiet reaches this side only with the next frame; a user who needs a clean
  // register file runs one short frame while reset is still high
  always_ff @(negedge link.sclk) begin
    rst_meta <= sys_rst;
    link_rst <= rst_meta;
  end

  // the whole word as it stands at the sixteenth falling edge
  assign word_in = {in_sh, link.mosi};
  assign word_done = (bit_cnt == `SPR_LAST_BIT);
  // reserved page codes and a pointer past the page end both fall outside the file
  assign page_ok = (page < `SPR_NUM_PAGES);
  assign in_page = (ptr < `SPR_PAGE_REGS);
  // pages are stacked in the file; only the low page bits matter once page_ok holds
  assign reg_idx = {page[1:0], ptr[4:0]};
  // writes land only inside a real page and before its end
  assign reg_we = word_done && !cmd_phase && !dir_read && page_ok && in_page; // see (R16) (R17)

  // frame counter: cleared while select is high, so the first word after a fall is a command
  // select high is an asynchronous clear, so no serial edge is needed to end an access:
  // a frame cut short by the master leaves no half word behind for the next one
  always_ff @(negedge link.sclk or posedge link.ss_n) begin
    if (link.ss_n) begin
      bit_cnt <= 4'h0; // see (R5) (R18)
      cmd_phase <= 1'b1;
      in_sh <= 15'h0000;
    end else begin
      bit_cnt <= bit_cnt + 4'h1; // wraps every sixteen bits, see (R15)
      in_sh <= word_in[14:0]; // see (R4)
      if (word_done && cmd_phase) cmd_phase <= 1'b0; // see (R6)
    end
  end

  // command decode and auto-incrementing pointer
  // the pointer stops one step past the six-bit range instead of wrapping, so a long
  // read never falls back onto the first register of the page; a start address in the
  // upper half of the address field already lies past the end of the page
  always_ff @(negedge link.sclk) begin
    if (link_rst) begin
      dir_read <= 1'b0;
      page <= 4'h0;
      ptr <= 7'h00;
    end else if (word_done && !link.ss_n) begin
      if (cmd_phase) begin
        dir_read <= (word_in[`SPR_CMD_RW_BIT] == `SPR_CMD_READ); // see (R7) (R11) (R14)
        page <= word_in[`SPR_CMD_PG_MSB:`SPR_CMD_PG_LSB]; // see (R8)
        ptr <= {1'b0, word_in[`SPR_CMD_AD_MSB:`SPR_CMD_AD_LSB]}; // see (R9)
      end else if (!ptr[6]) begin
        ptr <= ptr + 7'h01; // saturates past the page end, see (R12)
      end
    end
  end

  // register file, one flip-flop word per entry
  // one process per word keeps each entry with a single driver; the compare against
  // a constant index reduces to a one-hot write enable
  genvar gi;
  generate
    for (gi = 0; gi < `SPR_REG_COUNT; gi++) begin : g_reg
      always_ff @(negedge link.sclk) begin
        if (link_rst) regs[gi] <= 16'h0000;
        else if (reg_we && reg_idx == 7'(gi)) regs[gi] <= word_in; // see (R16)
      end
    end
  endgenerate

  // outgoing word; anything outside a real page reads as all ones
  // write frames land here as well: the master ignores data out while it writes,
  // and dir_read is part of the condition, so a write frame never sends register contents
  always_comb begin
    rd_word = `SPR_ALL_ONES; // see (R13) (R17)
    if (dir_read && page_ok && in_page) rd_word = regs[reg_idx];
  end

  // data out changes on the rising edge, the first edge of each bit
  // the index counts down from the top bit, so each word leaves most significant first;
  // during the command word the line stays low, since nothing has been asked for yet
  always_ff @(posedge link.sclk or posedge link.ss_n) begin
    if (link.ss_n) link.miso_out <= 1'b0;
    else link.miso_out <= cmd_phase ? 1'b0 : rd_word[`SPR_LAST_BIT - bit_cnt]; // see (R2) (R3) (R4)
  end

  // drive the line only while selected; the slave never starts anything itself
  // released, the line falls to its pull-down level rather than keeping the last bit
  assign link.miso_oe = ~link.ss_n; // see (R1)

  // write notice: word held stable, toggle crosses to the system clock
  // a toggle rather than a pulse, because the link clock may stop right after the
  // storing edge and a pulse would then never be seen on the other side
  always_ff @(negedge link.sclk) begin
    if (link_rst) begin
      note_tgl <= 1'b0;
      note_word <= 23'h000000;
    end else if (reg_we) begin
      note_tgl <= ~note_tgl;
      note_word <= {page[1:0], ptr[4:0], word_in};
    end
  end

  // toggle synchroniser; the held word is read only after the toggle has settled,
  // which limits back-to-back writes to one per sixteen link clocks (always true here)
  // only the second stage is read, so the first may settle for a whole clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tgl_meta <= 1'b0;
      tgl_s <= 1'b0;
      tgl_prev <= 1'b0;
    end else begin
      tgl_meta <= note_tgl;
      tgl_s <= tgl_meta;
      tgl_prev <= tgl_s;
    end
  end

  // user side notice: a one-cycle pulse per stored word, fields held until the next
  // the held word is copied only on a toggle edge, by which time it has been stable
  // for several system clocks, so no bit of it can be caught half changed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pulse <= 1'b0;
      wr_page <= 2'h0;
      wr_addr <= 5'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_pulse <= tgl_s ^ tgl_prev;
      if (tgl_s ^ tgl_prev) begin
        wr_page <= note_word[22:21];
        wr_addr <= note_word[20:16];
        wr_data <= note_word[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/spr_checker.sv ====
// spr_checker.sv: timing relations on the serial link of the paged register port
// assumes: instanced in tb_top beside the link interface; clock and sys_rst are the host side's
`timescale 1ns/1ps
`default_nettype none
module spr_checker (
  // serial link
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso,
  // system
  input wire logic clock,
  input wire logic sys_rst
);
  logic sclk_q;
  logic [4:0] rises;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // delayed serial clock, so rises can be seen in the system domain
  always_ff @(posedge clock) begin
    sclk_q <= sclk;
  end
  // serial rises since select fell; saturates so a long burst cannot wrap back into the command
  always_ff @(posedge clock) begin
    if (ss_n) begin
      rises <= 5'h00;
    end else if (sclk && !sclk_q && rises != 5'h1F) begin
      rises <= rises + 5'h01;
    end
  end
  property p_idle_low; ss_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock high while deselected");
  property p_oe; miso_oe == !ss_n; endproperty
  a_oe: assert property (p_oe) else $error("data out enable disagrees with select");
  property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("serial clock high phase not four cycles");
  property p_start; $fell(ss_n) |-> ##[1:6] $rose(sclk); endproperty
  a_start: assert property (p_start) else $error("no first serial edge after select fell");
  property p_frame; $fell(ss_n) |-> !ss_n [*8]; endproperty
  a_frame: assert property (p_frame) else $error("select released too early");
  property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data in moved while clock high");
  property p_miso; sclk && $past(sclk) |-> $stable(miso); endproperty
  a_miso: assert property (p_miso) else $error("data out moved while clock high");
  // skip each cycle in which a rise is seen; the first data bit stands only from the seventeenth rise, when the count is already sixteen
  property p_cmd_quiet; rises != 5'h00 && rises < 5'h10 && !(sclk && !sclk_q) |-> !miso; endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("data out not low during command");
  property p_out_quiet; ss_n |-> !miso_out; endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("data out driven while deselected");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// tb_top.sv: host end and device end joined by one link; user sides driven and checked here
// assumes: device registers clear only by a frame run while its reset is high
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic host_rst = 1'b1;
  logic dev_rst = 1'b1;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  logic [3:0] cmd_page = 4'h0;
  logic [5:0] cmd_addr = 6'h00, cmd_words = 6'h00;
  logic [15:0] wr_data = 16'h0000;
  logic cmd_ready, wr_ready, rd_valid, busy, wr_pulse, r;
  logic [15:0] rd_data, dev_data;
  logic [1:0] dev_page;
  logic [4:0] dev_addr;
  logic [15:0] mem [0:95];
  logic [22:0] wq[$], rq[$];
  int error_cnt = 0;
  int check_count = 0;
  spr_link_if link();
  spr_host u_spr_host (.link(link), .clock(clock), .sys_rst(host_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_page(cmd_page), .cmd_addr(cmd_addr),
    .cmd_words(cmd_words), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy));
  spr_dev u_spr_dev (.link(link), .clock(clock), .sys_rst(dev_rst), .wr_pulse(wr_pulse),
    .wr_page(dev_page), .wr_addr(dev_addr), .wr_data(dev_data));
  spr_checker u_spr_checker (.sclk(link.sclk), .ss_n(link.ss_n), .mosi(link.mosi),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe), .miso(link.miso), .clock(clock), .sys_rst(host_rst));
  initial forever #12.5 clock = ~clock;
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one framed access; expected words are noted before the link carries them
  task automatic xfer(input logic rd, input logic [3:0] pg, input logic [5:0] ad, input logic [5:0] n);
    logic [15:0] d;
    int p;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_page = pg;
    cmd_addr = ad;
    cmd_words = n;
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    check(23'({busy, cmd_ready}), 23'h000002);
    for (int i = 0; i < n; i++) begin
      p = ad + i;
      d = 16'($urandom);
      if (rd) rq.push_back({7'h00, (pg < 4'h3 && p < 32) ? mem[pg * 32 + p] : 16'hFFFF});
      else begin
        if (pg < 4'h3 && p < 32) begin
          mem[pg * 32 + p] = d;
          wq.push_back({pg[1:0], 5'(p), d});
        end
        wr_valid = 1'b1; // held up across words, dropped after the last
        wr_data = d;
        while (wr_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        check(23'(wr_ready), 23'h000000);
      end
    end
    wr_valid = 1'b0;
    while (busy !== 1'b0) @(negedge clock);
    repeat (20) @(negedge clock);
    $display("test done: read %0d page %0d addr %0d words %0d", rd, pg, ad, n);
  endtask
  // reader stalls at random, one cycle in four, far too briefly for the two-entry buffer to fill; checks the word popped at the next edge
  always @(negedge clock) begin
    r = ($urandom % 4) != 0;
    if (rd_valid === 1'b1 && r) check({7'h00, rd_data}, rq.size() ? rq.pop_front() : 23'h7FFFFF);
    rd_ready = r;
    if (wr_pulse === 1'b1) begin
      check({dev_page, dev_addr, dev_data}, wq.size() ? wq.pop_front() : 23'h7FFFFF);
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h315D05DD));
    repeat (8) @(negedge clock);
    host_rst = 1'b0;
    for (int i = 0; i < 96; i++) mem[i] = 16'h0000;
    xfer(1'b0, 4'h0, 6'h00, 6'h00); // dummy frame clears the device while its reset is high
    dev_rst = 1'b0;
    xfer(1'b1, 4'h0, 6'h00, 6'h02);
    xfer(1'b0, 4'h1, 6'h00, 6'h03);
    xfer(1'b0, 4'h2, 6'h1E, 6'h04);
    xfer(1'b0, 4'h3, 6'h00, 6'h02);
    xfer(1'b0, 4'hF, 6'h05, 6'h01);
    xfer(1'b0, 4'h0, 6'h28, 6'h02);
    xfer(1'b1, 4'h1, 6'h00, 6'h05);
    xfer(1'b1, 4'h2, 6'h1E, 6'h04);
    xfer(1'b1, 4'h3, 6'h00, 6'h02);
    for (int i = 0; i < 8; i++) begin
      xfer(1'($urandom), 4'($urandom % 4), 6'($urandom), 6'($urandom % 5));
    end
    check(23'(rq.size() + wq.size()), 23'h000000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
